// file: include/otgcv_pkg.sv
package otgcv_pkg;

    // ****************************************
    // register map and power-on defaults
    // ****************************************
    localparam logic [7:0] OFF_OTG_CONTROL_THREE = 8'h10;
    localparam logic [7:0] OFF_LDO_AND_CHARGE_VOLTAGE_HIGH = 8'h11;
    localparam logic [7:0] OFF_CHARGE_VOLTAGE_LOW = 8'h12;
    localparam logic [7:0] OFF_OTG_VOLTAGE_HIGH = 8'h13;
    localparam logic [7:0] OFF_OTG_VOLTAGE_LOW = 8'h14;

    localparam logic [7:0] RST_OTG_CONTROL_THREE = 8'h78;
    localparam logic [7:0] RST_LDO_AND_CHARGE_VOLTAGE_HIGH = 8'hF1;
    localparam logic [7:0] RST_CHARGE_VOLTAGE_LOW = 8'h54;
    localparam logic [7:0] RST_OTG_VOLTAGE_HIGH = 8'hA0;
    localparam logic [7:0] RST_OTG_VOLTAGE_LOW = 8'hD6;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SLEW_LSB = 6;
    localparam int RAMP_SINK_BIT = 5;
    localparam int OV_SINK_BIT = 4;
    localparam int BAT_ILIM_LSB = 2;
    localparam int IGNORE_LDO_FAULT_BIT = 1;
    localparam int PULSE_SKIP_DIS_BIT = 0;
    localparam int LDO_CODE_LSB = 3;
    localparam int FB_SELECT_BIT = 3;
    localparam int OTG_CODE_LOW_LSB = 1;

    // ****************************************
    // codes and scaling
    // ****************************************
    localparam logic [1:0] ILIM_OFF = 2'h0;
    localparam logic [1:0] ILIM_200 = 2'h2;
    localparam logic [10:0] CHARGE_CODE_MAX = 11'h6D6;
    localparam logic [6:0] PCT_MIN = 7'h01;
    localparam logic [6:0] PCT_MAX = 7'h64;
    localparam logic [12:0] LDO_BASE_MV = 13'h07D0;
    localparam logic [12:0] LDO_STEP_MV = 13'h0064;
    localparam logic [14:0] CHARGE_BASE_MV = 15'h1388;
    localparam logic [14:0] CHARGE_STEP_MV = 15'h000A;
    localparam logic [14:0] OTG_BASE_MV = 15'h0B90;
    localparam logic [14:0] OTG_STEP_MV = 15'h0014;

    // ****************************************
    // slew timing: one 20 mV code step per tick
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int OTG_STEP_UV = 20000;
    localparam int SLEW_RATE_0_UV_PER_US = 1000;
    localparam int SLEW_RATE_1_UV_PER_US = 500;
    localparam int SLEW_RATE_2_UV_PER_US = 330;
    localparam int SLEW_RATE_3_UV_PER_US = 100;
    localparam logic [11:0] SLEW_CYC_0 = 12'(OTG_STEP_UV * 1000 / (SLEW_RATE_0_UV_PER_US * CLK_PERIOD_NS));
    localparam logic [11:0] SLEW_CYC_1 = 12'(OTG_STEP_UV * 1000 / (SLEW_RATE_1_UV_PER_US * CLK_PERIOD_NS));
    localparam logic [11:0] SLEW_CYC_2 = 12'(OTG_STEP_UV * 1000 / (SLEW_RATE_2_UV_PER_US * CLK_PERIOD_NS));
    localparam logic [11:0] SLEW_CYC_3 = 12'(OTG_STEP_UV * 1000 / (SLEW_RATE_3_UV_PER_US * CLK_PERIOD_NS));

    typedef enum logic [2:0] {
        OTGCV_HOLD = 3'b001,
        OTGCV_UP = 3'b010,
        OTGCV_DOWN = 3'b100
    } otgcv_ramp_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } otgcv_req_s;

endpackage : otgcv_pkg

// file: logic/otgcv_regs.sv
`timescale 1ns/100ps
// Behaviour
// R1: internal feedback ramps the applied OTG code toward target at the selected slew rate.
// R2: ramp-down sink is on while ramping down with internal feedback and enable set.
// R3: overvoltage sink is on whenever overvoltage is present and its enable is set.
// R4: battery-side limit is off, 150% or 200% of fast-charge scale per code.
// R5: an LDO fault stops OTG unless the fault is ignored.
// R6: pulse-skip disable forces fixed-frequency switching in both modes.
// R7: LDO output is 2V plus 100mV per five-bit code step.
// R8: eleven-bit charge code spans two registers, 5V plus 10mV per step.
// R9: charge codes above the 22.5V code are clamped to it.
// R10: feedback select chooses register code or external divider for the OTG output.
// R11: ten-bit OTG code spans two registers, 2.96V plus 20mV per step.
// R12: host keeps the four reserved bits of the OTG high register at default.
// R13: every register reads back and powers up with its stored default.
// R14: fast-charge scale is a seven-bit percentage clamped to 1..100.
// R15: a new OTG target applies only once both bytes have been written.
module otgcv_regs (
    input wire logic clk,
    input wire logic rst,
    input wire otgcv_pkg::otgcv_req_s req,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] fast_charge_current_scale,
    input wire logic otg_overvoltage,
    input wire logic ldo_fault,
    output logic [9:0] boost_output_voltage_code,
    output logic [14:0] otg_target_mv,
    output logic pulldown_sink_on,
    output logic feedback_external,
    output logic battery_limit_enable,
    output logic [7:0] battery_limit_pct,
    output logic otg_stop_req,
    output logic pulse_skip_disable,
    output logic [12:0] ldo_voltage_mv,
    output logic [10:0] charge_voltage_code,
    output logic [14:0] charge_voltage_mv
);

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] ctrl3_reg;
    logic [7:0] vhigh_reg;
    logic [7:0] vlow_reg;
    logic [7:0] ohigh_reg;
    logic [7:0] olow_reg;
    logic ohigh_pend_reg;
    logic olow_pend_reg;
    logic [9:0] target_reg;
    logic [9:0] applied_reg;
    logic [11:0] tick_reg;
    otgcv_pkg::otgcv_ramp_e ramp_reg;
    otgcv_pkg::otgcv_ramp_e ramp_next;

    wire wr_ctrl3 = req.wr && req.addr == otgcv_pkg::OFF_OTG_CONTROL_THREE;
    wire wr_vhigh = req.wr && req.addr == otgcv_pkg::OFF_LDO_AND_CHARGE_VOLTAGE_HIGH;
    wire wr_vlow = req.wr && req.addr == otgcv_pkg::OFF_CHARGE_VOLTAGE_LOW;
    wire wr_ohigh = req.wr && req.addr == otgcv_pkg::OFF_OTG_VOLTAGE_HIGH;
    wire wr_olow = req.wr && req.addr == otgcv_pkg::OFF_OTG_VOLTAGE_LOW;

    // ****************************************
    // field decode
    // ****************************************
    wire [1:0] output_slew_select = ctrl3_reg[otgcv_pkg::SLEW_LSB +: 2];
    wire ramp_down_sink_enable = ctrl3_reg[otgcv_pkg::RAMP_SINK_BIT];
    wire overvoltage_sink_enable = ctrl3_reg[otgcv_pkg::OV_SINK_BIT];
    wire [1:0] battery_side_current_limit = ctrl3_reg[otgcv_pkg::BAT_ILIM_LSB +: 2];
    wire ignore_ldo_fault = ctrl3_reg[otgcv_pkg::IGNORE_LDO_FAULT_BIT];
    wire pulse_skip_disable_bit = ctrl3_reg[otgcv_pkg::PULSE_SKIP_DIS_BIT];
    wire [4:0] ldo_voltage_code = vhigh_reg[otgcv_pkg::LDO_CODE_LSB +: 5];
    wire [10:0] charge_code_raw = {vhigh_reg[2:0], vlow_reg}; // [R8]
    wire feedback_source_select = ohigh_reg[otgcv_pkg::FB_SELECT_BIT];

    // the live pair is only a candidate; target_reg is what regulation sees
    wire [9:0] code_written = {ohigh_reg[2:0], olow_reg[otgcv_pkg::OTG_CODE_LOW_LSB +: 7]}; // [R11]
    wire commit = (wr_ohigh && (olow_pend_reg || wr_olow)) || (wr_olow && ohigh_pend_reg); // [R15]
    wire [9:0] commit_code = {wr_ohigh ? req.wdata[2:0] : ohigh_reg[2:0],
                              wr_olow ? req.wdata[7:1] : olow_reg[7:1]};

    // ****************************************
    // slew engine
    // ****************************************
    wire [11:0] slew_cycles = (output_slew_select == 2'h0) ? otgcv_pkg::SLEW_CYC_0 :
                              (output_slew_select == 2'h1) ? otgcv_pkg::SLEW_CYC_1 :
                              (output_slew_select == 2'h2) ? otgcv_pkg::SLEW_CYC_2 :
                              otgcv_pkg::SLEW_CYC_3; // [R1]
    wire tick_done = tick_reg >= slew_cycles - 12'h001;
    wire internal_fb = !feedback_source_select;

    always_comb begin
        if (!internal_fb || applied_reg == target_reg) begin
            ramp_next = otgcv_pkg::OTGCV_HOLD;
        end else if (applied_reg < target_reg) begin
            ramp_next = otgcv_pkg::OTGCV_UP;
        end else begin
            ramp_next = otgcv_pkg::OTGCV_DOWN;
        end
    end

    logic [9:0] applied_next;
    always_comb begin
        case (ramp_reg)
            otgcv_pkg::OTGCV_UP: applied_next = tick_done ? applied_reg + 10'h001 : applied_reg; // [R1]
            otgcv_pkg::OTGCV_DOWN: applied_next = tick_done ? applied_reg - 10'h001 : applied_reg; // [R1]
            default: applied_next = applied_reg;
        endcase
        // external divider sets the output, so the code simply tracks [R10]
        if (!internal_fb) begin
            applied_next = target_reg;
        end
    end

    // ****************************************
    // derived controls
    // ****************************************
    wire [6:0] pct_clamped = (fast_charge_current_scale < otgcv_pkg::PCT_MIN) ? otgcv_pkg::PCT_MIN :
                             (fast_charge_current_scale > otgcv_pkg::PCT_MAX) ? otgcv_pkg::PCT_MAX :
                             fast_charge_current_scale; // [R14]
    // nine bits so that 150% of a full-scale setting cannot wrap before the halving
    wire [8:0] pct_x3 = 9'(pct_clamped) * 9'h003; // [R4]
    wire [7:0] pct_150 = pct_x3[8:1];
    wire [7:0] pct_200 = {pct_clamped, 1'b0};
    wire [7:0] limit_pct_next = (battery_side_current_limit == otgcv_pkg::ILIM_OFF) ? 8'h00 :
                                (battery_side_current_limit == otgcv_pkg::ILIM_200) ? pct_200 : pct_150; // [R4]
    wire [10:0] charge_clamped = (charge_code_raw > otgcv_pkg::CHARGE_CODE_MAX) ?
                                 otgcv_pkg::CHARGE_CODE_MAX : charge_code_raw; // [R9]
    wire sink_next = (ramp_down_sink_enable && internal_fb && ramp_reg == otgcv_pkg::OTGCV_DOWN) ||
                     (overvoltage_sink_enable && otg_overvoltage); // [R2] [R3]
    wire [7:0] rdata_next = (req.addr == otgcv_pkg::OFF_OTG_CONTROL_THREE) ? ctrl3_reg :
                            (req.addr == otgcv_pkg::OFF_LDO_AND_CHARGE_VOLTAGE_HIGH) ? vhigh_reg :
                            (req.addr == otgcv_pkg::OFF_CHARGE_VOLTAGE_LOW) ? vlow_reg :
                            (req.addr == otgcv_pkg::OFF_OTG_VOLTAGE_HIGH) ? ohigh_reg :
                            (req.addr == otgcv_pkg::OFF_OTG_VOLTAGE_LOW) ? olow_reg : 8'h00;

    // ****************************************
    // registers
    // ****************************************
    // reset stands in for the nonvolatile load of defaults
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl3_reg <= otgcv_pkg::RST_OTG_CONTROL_THREE; // [R13]
            vhigh_reg <= otgcv_pkg::RST_LDO_AND_CHARGE_VOLTAGE_HIGH; // [R13]
            vlow_reg <= otgcv_pkg::RST_CHARGE_VOLTAGE_LOW; // [R13]
            ohigh_reg <= otgcv_pkg::RST_OTG_VOLTAGE_HIGH; // [R13]
            olow_reg <= otgcv_pkg::RST_OTG_VOLTAGE_LOW; // [R13]
        end else begin
            if (wr_ctrl3) ctrl3_reg <= req.wdata;
            if (wr_vhigh) vhigh_reg <= req.wdata;
            if (wr_vlow) vlow_reg <= req.wdata;
            // reserved high bits are stored as written; keeping them is the host's job
            if (wr_ohigh) ohigh_reg <= req.wdata;
            if (wr_olow) olow_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ohigh_pend_reg <= 1'b0;
            olow_pend_reg <= 1'b0;
            target_reg <= {otgcv_pkg::RST_OTG_VOLTAGE_HIGH[2:0], otgcv_pkg::RST_OTG_VOLTAGE_LOW[7:1]};
        end else begin
            ohigh_pend_reg <= !commit && (ohigh_pend_reg || wr_ohigh); // [R15]
            olow_pend_reg <= !commit && (olow_pend_reg || wr_olow); // [R15]
            if (commit) target_reg <= commit_code; // [R15]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            applied_reg <= {otgcv_pkg::RST_OTG_VOLTAGE_HIGH[2:0], otgcv_pkg::RST_OTG_VOLTAGE_LOW[7:1]};
            tick_reg <= 12'h000;
            ramp_reg <= otgcv_pkg::OTGCV_HOLD;
        end else begin
            applied_reg <= applied_next;
            ramp_reg <= ramp_next;
            tick_reg <= (ramp_reg == otgcv_pkg::OTGCV_HOLD || tick_done) ? 12'h000 : tick_reg + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            boost_output_voltage_code <= 10'h000;
            otg_target_mv <= 15'h0000;
            pulldown_sink_on <= 1'b0;
            feedback_external <= 1'b0;
            battery_limit_enable <= 1'b0;
            battery_limit_pct <= 8'h00;
            otg_stop_req <= 1'b0;
            pulse_skip_disable <= 1'b0;
            ldo_voltage_mv <= 13'h0000;
            charge_voltage_code <= 11'h000;
            charge_voltage_mv <= 15'h0000;
        end else begin
            reg_rdata <= req.rd ? rdata_next : reg_rdata; // [R13]
            boost_output_voltage_code <= applied_reg;
            otg_target_mv <= otgcv_pkg::OTG_BASE_MV + 15'(applied_reg) * otgcv_pkg::OTG_STEP_MV; // [R11]
            pulldown_sink_on <= sink_next; // [R2] [R3]
            feedback_external <= feedback_source_select; // [R10]
            battery_limit_enable <= battery_side_current_limit != otgcv_pkg::ILIM_OFF; // [R4]
            battery_limit_pct <= limit_pct_next; // [R4]
            otg_stop_req <= ldo_fault && !ignore_ldo_fault; // [R5]
            pulse_skip_disable <= pulse_skip_disable_bit; // [R6]
            ldo_voltage_mv <= otgcv_pkg::LDO_BASE_MV + 13'(ldo_voltage_code) * otgcv_pkg::LDO_STEP_MV; // [R7]
            charge_voltage_code <= charge_clamped; // [R9]
            charge_voltage_mv <= otgcv_pkg::CHARGE_BASE_MV + 15'(charge_clamped) * otgcv_pkg::CHARGE_STEP_MV; // [R8]
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_slew_step;
        @(posedge clk) disable iff (rst)
        (internal_fb && $past(internal_fb) && applied_reg != $past(applied_reg)) |->
            $past(tick_done) && (applied_reg - $past(applied_reg) == 10'h001 ||
                                 $past(applied_reg) - applied_reg == 10'h001);
    endproperty
    a_slew_step: assert property (p_slew_step) else $error("applied code moved off a slew tick"); // [R1]

    property p_ramp_sink;
        @(posedge clk) disable iff (rst)
        (ramp_reg == otgcv_pkg::OTGCV_DOWN && ramp_down_sink_enable && internal_fb) |=> pulldown_sink_on;
    endproperty
    a_ramp_sink: assert property (p_ramp_sink) else $error("sink off during ramp down"); // [R2]

    property p_ov_sink;
        @(posedge clk) disable iff (rst)
        (overvoltage_sink_enable && otg_overvoltage) [*2] |=> pulldown_sink_on [*1];
    endproperty
    a_ov_sink: assert property (p_ov_sink) else $error("sink off during overvoltage"); // [R3]

    property p_limit;
        @(posedge clk) disable iff (rst)
        (battery_side_current_limit == otgcv_pkg::ILIM_200 && pct_clamped == otgcv_pkg::PCT_MAX) |=>
            battery_limit_pct == 8'hC8 && battery_limit_enable;
    endproperty
    a_limit: assert property (p_limit) else $error("200 percent limit wrong"); // [R4]

    property p_ldo_fault;
        @(posedge clk) disable iff (rst)
        (ldo_fault && ignore_ldo_fault) |=> !otg_stop_req;
    endproperty
    a_ldo_fault: assert property (p_ldo_fault) else $error("ignored fault still stops otg"); // [R5]

    property p_pulse_skip;
        @(posedge clk) disable iff (rst)
        wr_ctrl3 |-> ##2 pulse_skip_disable == $past(req.wdata[0], 2);
    endproperty
    a_pulse_skip: assert property (p_pulse_skip) else $error("pulse skip disable not applied"); // [R6]

    property p_ldo_mv;
        @(posedge clk) disable iff (rst)
        $stable(ldo_voltage_code) |=> ldo_voltage_mv >= 13'h07D0 && ldo_voltage_mv <= 13'h13EC;
    endproperty
    a_ldo_mv: assert property (p_ldo_mv) else $error("ldo voltage outside 2V..5.1V"); // [R7]

    property p_charge_clamp;
        @(posedge clk) disable iff (rst)
        1'b1 |=> charge_voltage_code <= 11'h6D6 && charge_voltage_mv <= 15'h57E4;
    endproperty
    a_charge_clamp: assert property (p_charge_clamp) else $error("charge target above 22.5V"); // [R9]

    property p_readback;
        @(posedge clk) disable iff (rst)
        (wr_vlow ##1 !wr_vlow ##1 (req.rd && req.addr == otgcv_pkg::OFF_CHARGE_VOLTAGE_LOW && !req.wr)) |=>
            reg_rdata == $past(req.wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("charge low register readback wrong"); // [R13]

    property p_both_bytes;
        @(posedge clk) disable iff (rst)
        (target_reg != $past(target_reg)) |-> $past(commit);
    endproperty
    a_both_bytes: assert property (p_both_bytes) else $error("target moved without both bytes"); // [R15]

    property p_commit_code;
        @(posedge clk) disable iff (rst)
        commit |=> target_reg == code_written;
    endproperty
    a_commit_code: assert property (p_commit_code) else $error("committed target differs from the byte pair"); // [R11] [R15]

    property p_ext_track;
        @(posedge clk) disable iff (rst)
        (!internal_fb && $past(!internal_fb)) |-> applied_reg == $past(target_reg);
    endproperty
    a_ext_track: assert property (p_ext_track) else $error("external feedback code not tracking target"); // [R10]

    property p_sink_idle;
        @(posedge clk) disable iff (rst)
        (!otg_overvoltage && ramp_reg != otgcv_pkg::OTGCV_DOWN) |=> !pulldown_sink_on;
    endproperty
    a_sink_idle: assert property (p_sink_idle) else $error("sink on with no ramp down or overvoltage"); // [R2] [R3]

    property p_limit_off;
        @(posedge clk) disable iff (rst)
        (battery_side_current_limit == otgcv_pkg::ILIM_OFF) |=> !battery_limit_enable && battery_limit_pct == 8'h00;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("battery limit active while disabled"); // [R4]

    property p_limit_150;
        @(posedge clk) disable iff (rst)
        (battery_side_current_limit == 2'h3 && pct_clamped == otgcv_pkg::PCT_MAX) |=> battery_limit_pct == 8'h96;
    endproperty
    a_limit_150: assert property (p_limit_150) else $error("150 percent limit wrong"); // [R4]

    property p_stop;
        @(posedge clk) disable iff (rst)
        (ldo_fault && !ignore_ldo_fault) |=> otg_stop_req;
    endproperty
    a_stop: assert property (p_stop) else $error("unignored ldo fault does not stop otg"); // [R5]

endmodule : otgcv_regs

// file: tb/otgcv_host.sv
`timescale 1ns/100ps
// ****************************************
// host side of the register port
// ****************************************
module otgcv_host (
    input wire logic clk,
    output otgcv_pkg::otgcv_req_s req,
    input wire logic [7:0] reg_rdata
);
    initial begin
        req = '0;
    end

    // released address and data lines show the inverse of their last value and wr, rd drop to 0, so stale data never looks valid
    task automatic release_bus();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask : release_bus

    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        req.addr = addr;
        req.wdata = data;
        req.wr = 1'b1;
        @(negedge clk);
        release_bus();
    endtask : write

    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        req.addr = addr;
        req.rd = 1'b1;
        @(negedge clk);
        data = reg_rdata;
        release_bus();
    endtask : read

    task automatic write_otg(input logic fb, input logic [9:0] code);
        write(otgcv_pkg::OFF_OTG_VOLTAGE_HIGH, {otgcv_pkg::RST_OTG_VOLTAGE_HIGH[7:4], fb, code[9:7]});
        write(otgcv_pkg::OFF_OTG_VOLTAGE_LOW, {code[6:0], 1'b0});
    endtask : write_otg
endmodule : otgcv_host

// file: tb/otgcv_regs_bench.sv
`timescale 1ns/100ps
module otgcv_regs_bench;
    logic clk, rst, ov, fault, fb_ext, sink, lim_en, stop, pskip;
    otgcv_pkg::otgcv_req_s req;
    logic [7:0] rdata, rd, pct;
    logic [6:0] scale;
    logic [9:0] code;
    logic [14:0] tgt_mv, chg_mv;
    logic [12:0] ldo_mv;
    logic [10:0] chg_code;
    int fails, total_checks, n, c;
    logic [7:0] r11 [3] = '{8'h07, 8'hFE, 8'h06};
    logic [7:0] r12 [3] = '{8'hFF, 8'hD6, 8'hD5};
    logic [10:0] ecode [3] = '{11'h6D6, 11'h6D6, 11'h6D5};
    logic [6:0] scales [3] = '{7'h00, 7'h33, 7'h7F};
    logic [7:0] pats [5] = '{8'hC3, 8'h2C, 8'hB5, 8'hA6, 8'h3C};
    int slew_cyc [4];

    initial clk = 1'b0;
    always #50 clk = ~clk;

    otgcv_host u_otgcv_host (.clk(clk), .req(req), .reg_rdata(rdata));
    otgcv_regs u_otgcv_regs (.clk(clk), .rst(rst), .req(req), .reg_rdata(rdata),
        .fast_charge_current_scale(scale), .otg_overvoltage(ov), .ldo_fault(fault),
        .boost_output_voltage_code(code), .otg_target_mv(tgt_mv), .pulldown_sink_on(sink),
        .feedback_external(fb_ext), .battery_limit_enable(lim_en), .battery_limit_pct(pct),
        .otg_stop_req(stop), .pulse_skip_disable(pskip), .ldo_voltage_mv(ldo_mv),
        .charge_voltage_code(chg_code), .charge_voltage_mv(chg_mv));

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask : settle

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        u_otgcv_host.read(addr, rd);
        chk(rd, exp);
    endtask : rchk

    // bounded wait for the applied code to reach the target, cycles waited in n
    task automatic wait_code(input logic [9:0] t, input int lim);
        n = 0;
        while (code !== t && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_code

    initial begin
        #2_000_000;
        fails++;
        $display("Error at %0t: got %0h expected %0h", $time, code, 0);
        close_out();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        slew_cyc = '{otgcv_pkg::SLEW_CYC_0, otgcv_pkg::SLEW_CYC_1, otgcv_pkg::SLEW_CYC_2, otgcv_pkg::SLEW_CYC_3};
        rst = 1'b1;
        scale = 7'h33;
        ov = 1'b0;
        fault = 1'b0;
        settle(3);
        rst = 1'b0;
        settle(4);
        rchk(8'h10, 8'h78);
        rchk(8'h11, 8'hF1);
        rchk(8'h12, 8'h54);
        rchk(8'h13, 8'hA0);
        rchk(8'h14, 8'hD6);
        rchk(8'h0F, 8'h00);
        chk(chg_code, 11'h154);
        chk(chg_mv, 32'd8400);
        chk(ldo_mv, 32'd5000);
        chk(code, 32'd107);
        chk(tgt_mv, 32'd5100);
        chk(pct, 32'd102);
        chk(fb_ext, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_otgcv_host.write(8'h11, r11[i]);
            u_otgcv_host.write(8'h12, r12[i]);
            settle(3);
            chk(chg_code, ecode[i]);
            chk(chg_mv, 5000 + 10 * ecode[i]);
            chk(ldo_mv, 2000 + 100 * r11[i][7:3]);
        end
        for (int s = 0; s < 3; s++) begin
            for (int l = 0; l < 4; l++) begin
                scale = scales[s];
                c = (scales[s] < 1) ? 1 : (scales[s] > 100) ? 100 : scales[s];
                u_otgcv_host.write(8'h10, 8'h30 | 8'(l << 2));
                settle(3);
                chk(lim_en, l != 0);
                chk(pct, (l == 0) ? 0 : (l == 2) ? 2 * c : c * 3 / 2);
            end
        end
        fault = 1'b1;
        u_otgcv_host.write(8'h10, 8'h30);
        settle(3);
        chk(stop, 1'b1);
        u_otgcv_host.write(8'h10, 8'h32);
        settle(3);
        chk(stop, 1'b0);
        fault = 1'b0;
        ov = 1'b1;
        u_otgcv_host.write(8'h10, 8'h31);
        settle(3);
        chk(pskip, 1'b1);
        chk(sink, 1'b1);
        u_otgcv_host.write(8'h10, 8'h20);
        settle(3);
        chk(sink, 1'b0);
        chk(pskip, 1'b0);
        ov = 1'b0;
        for (int sl = 0; sl < 4; sl++) begin
            u_otgcv_host.write(8'h10, 8'(sl << 6) | 8'h30);
            u_otgcv_host.write_otg(1'b0, 10'(108 + sl));
            wait_code(10'(108 + sl), 3000);
            chk(n >= slew_cyc[sl] - 2 && n <= slew_cyc[sl] + 8, 1'b1);
        end
        u_otgcv_host.write(8'h10, 8'h30);
        u_otgcv_host.write_otg(1'b0, 10'd110);
        settle(20);
        chk(sink, 1'b1);
        wait_code(10'd110, 400);
        settle(3);
        chk(sink, 1'b0);
        u_otgcv_host.write(8'h10, 8'h10);
        u_otgcv_host.write_otg(1'b0, 10'd109);
        settle(20);
        chk(sink, 1'b0);
        wait_code(10'd109, 400);
        u_otgcv_host.write(8'h10, 8'h30);
        // only the high byte: the code must stay where it is until the low byte lands
        u_otgcv_host.write(8'h13, 8'hAF);
        settle(30);
        chk(code, 32'd109);
        chk(tgt_mv, 32'd5140);
        u_otgcv_host.write(8'h14, 8'hFE);
        settle(4);
        chk(code, 10'h3FF);
        chk(tgt_mv, 32'd23420);
        chk(fb_ext, 1'b1);
        u_otgcv_host.write_otg(1'b1, 10'h000);
        settle(4);
        chk(code, 10'h000);
        chk(tgt_mv, 32'd2960);
        chk(sink, 1'b0);
        u_otgcv_host.write(8'h15, 8'hFF);
        rchk(8'h15, 8'h00);
        for (int a = 0; a < 5; a++) begin
            u_otgcv_host.write(8'(8'h10 + a), pats[a]);
            rchk(8'(8'h10 + a), pats[a]);
        end
        rst = 1'b1;
        settle(3);
        rst = 1'b0;
        settle(3);
        rchk(8'h10, 8'h78);
        rchk(8'h13, 8'hA0);
        close_out();
    end
endmodule : otgcv_regs_bench
